// ### rtl/fsh_pkg.sv
// fsh_pkg: register map, field positions and reset values for the
// fault status and handler state block.
// assumes a plain word-addressed register port with byte offsets.
`default_nettype none
package fsh_pkg;
  localparam int unsigned ADDR_W = 8;
  // register byte offsets, one word apart
  localparam logic [7:0] OFF_HANDLER = 8'h00;
  localparam logic [7:0] OFF_CFSR = 8'h04;
  localparam logic [7:0] OFF_FAULT_ADDR = 8'h08;
  // handler state register fields
  localparam int unsigned HS_MEM_ACT = 0;
  localparam int unsigned HS_BUS_ACT = 1;
  localparam int unsigned HS_USG_ACT = 3;
  localparam int unsigned HS_SVC_ACT = 7;
  localparam int unsigned HS_MON_ACT = 8;
  localparam int unsigned HS_PSV_ACT = 10;
  localparam int unsigned HS_TICK_ACT = 11;
  localparam int unsigned HS_USG_PEND = 12;
  localparam int unsigned HS_MEM_PEND = 13;
  localparam logic [31:0] HS_MASK = 32'h00003D8B;
  // configurable fault status fields
  localparam int unsigned CF_IACC = 0;
  localparam int unsigned CF_DACC = 1;
  localparam int unsigned CF_UNSTK = 3;
  localparam int unsigned CF_STK = 4;
  localparam int unsigned CF_ADDR_VALID = 7;
  localparam int unsigned CF_MISALIGNED_ACCESS_FLAG = 24;
  localparam int unsigned CF_DIVZERO = 25;
  localparam logic [31:0] CF_MASK = 32'h0300009B;
  localparam logic [31:0] HS_RESET = 32'h00000000;
  localparam logic [31:0] CF_RESET = 32'h00000000;
  localparam logic [31:0] FA_RESET = 32'h00000000;
  localparam int unsigned N_HANDLERS = 9;
endpackage : fsh_pkg
`default_nettype wire

// ### rtl/fsh_flag.sv
// fsh_flag: one sticky status bit that hardware sets and software
// writes; a hardware set in the same cycle beats a software clear.
// assumes CLK and synchronous active-low RESETN.
`timescale 1ns/1ps
`default_nettype none
module fsh_flag (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hw_set,
  input wire logic hw_clr,
  input wire logic sw_wr,
  input wire logic sw_val,
  output logic q
);
  logic q_reg;
  logic q_next;

  always_comb begin
    q_next = q_reg;
    if (sw_wr) begin
      q_next = sw_val;
    end
    if (hw_clr) begin
      q_next = 1'b0;
    end
    // set wins so an event is never lost against a clear
    if (hw_set) begin
      q_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule : fsh_flag
`default_nettype wire

// ### rtl/fsh_cfsr_byte.sv
// fsh_cfsr_byte: memory-management fault status byte plus fault
// address capture. sticky bits are cleared by writing one.
// assumes the core pulses one fault event per cycle at most.
`timescale 1ns/1ps
`default_nettype none
module fsh_cfsr_byte (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ev_iacc,
  input wire logic ev_dacc,
  input wire logic [31:0] ev_addr,
  input wire logic ev_unstk,
  input wire logic ev_stk,
  input wire logic w1c,
  input wire logic [7:0] w1c_data,
  output logic [7:0] status,
  output logic [31:0] fault_addr
);
  logic [7:0] st_reg;
  logic [7:0] st_next;
  logic [31:0] fa_reg;
  logic [31:0] fa_next;
  logic [7:0] set_v;

  always_comb begin
    set_v = 8'h00;
    set_v[fsh_pkg::CF_IACC] = ev_iacc;
    set_v[fsh_pkg::CF_DACC] = ev_dacc;
    set_v[fsh_pkg::CF_UNSTK] = ev_unstk;
    set_v[fsh_pkg::CF_STK] = ev_stk;
    set_v[fsh_pkg::CF_ADDR_VALID] = ev_dacc;
    st_next = st_reg;
    fa_next = fa_reg;
    if (w1c) begin
      st_next = st_reg & ~w1c_data;
    end
    st_next = (st_next | set_v) & fsh_pkg::CF_MASK[7:0];
    // only a data violation captures an address; others leave it
    if (ev_dacc) begin
      fa_next = ev_addr; // see RULE9
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= fsh_pkg::CF_RESET[7:0];
      fa_reg <= fsh_pkg::FA_RESET;
    end else begin
      st_reg <= st_next;
      fa_reg <= fa_next;
    end
  end

  assign status = st_reg;
  assign fault_addr = fa_reg;
endmodule : fsh_cfsr_byte
`default_nettype wire

// ### rtl/fsh_top.sv
// fsh_top: handler pending/active state and configurable fault status
// of a 32-bit core, reached through a plain register port.
// assumes exception entry/return logic gives one-cycle event pulses
// synchronous to CLK; RESETN is the core (warm) reset.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1 - mem-manage and usage pending flags read state; writes set or clear
// RULE2 - tick-timer active shows state; software write changes it directly
// RULE3 - pendable-service, debug-monitor, supervisor-call active show state
// RULE4 - usage, bus, mem-manage fault active flags show handler state
// RULE5 - software adjusts stacked context before changing an active flag
// RULE6 - software changes one handler bit by read-modify-write
// RULE7 - instruction fetch to never-execute region sets bit 0
// RULE8 - instruction violation leaves fault address register unwritten
// RULE9 - data violation sets bit 1 and captures attempted address
// RULE10 - unstacking violation sets bit 3, no fault address written
// RULE11 - stacking violation sets bit 4, no fault address written
// RULE12 - fault status resets zero; divide bit 25, misaligned_access_flag bit 24
// RULE13 - core reset clears these flags; debug logic is untouched
// RULE14 - no access or event combination can stall the register port
module fsh_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [fsh_pkg::ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // per-handler events, bit order as the handler slots of slot_bit below
  input wire logic [fsh_pkg::N_HANDLERS-1:0] HND_ENTER,
  input wire logic [fsh_pkg::N_HANDLERS-1:0] HND_RETURN,
  input wire logic MEM_PEND_SET,
  input wire logic USG_PEND_SET,
  input wire logic FLT_IACC,
  input wire logic FLT_DACC,
  input wire logic [31:0] FLT_ADDR,
  input wire logic FLT_UNSTK,
  input wire logic FLT_STK,
  input wire logic FLT_MISALIGNED_ACCESS_FLAG,
  input wire logic FLT_DIVZERO,
  output logic [fsh_pkg::N_HANDLERS-1:0] HND_STATE
);
  // handler slots: 0 mem act,1 bus act,2 usg act,3 svc act,4 mon act,
  // 5 psv act,6 tick act,7 usg pend,8 mem pend
  function automatic int unsigned slot_bit(input int unsigned i);
    case (i)
      0: slot_bit = fsh_pkg::HS_MEM_ACT;
      1: slot_bit = fsh_pkg::HS_BUS_ACT;
      2: slot_bit = fsh_pkg::HS_USG_ACT;
      3: slot_bit = fsh_pkg::HS_SVC_ACT;
      4: slot_bit = fsh_pkg::HS_MON_ACT;
      5: slot_bit = fsh_pkg::HS_PSV_ACT;
      6: slot_bit = fsh_pkg::HS_TICK_ACT;
      7: slot_bit = fsh_pkg::HS_USG_PEND;
      default: slot_bit = fsh_pkg::HS_MEM_PEND;
    endcase
  endfunction : slot_bit

  function automatic logic hit(input logic [fsh_pkg::ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off[fsh_pkg::ADDR_W-1:0]);
  endfunction : hit

  logic wr_hs;
  logic wr_cf;
  logic [fsh_pkg::N_HANDLERS-1:0] hs_q;
  logic [fsh_pkg::N_HANDLERS-1:0] hs_set;
  logic [fsh_pkg::N_HANDLERS-1:0] hs_clr;
  logic [7:0] mm_status;
  logic [31:0] fault_addr;
  logic [1:0] ud_reg;
  logic [1:0] ud_next;
  logic [31:0] hs_word;
  logic [31:0] cf_word;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  assign wr_hs = WR && hit(ADDR, fsh_pkg::OFF_HANDLER);
  assign wr_cf = WR && hit(ADDR, fsh_pkg::OFF_CFSR);

  // pending set by core, cleared when that handler is entered
  always_comb begin
    hs_set = HND_ENTER;
    hs_clr = HND_RETURN;
    hs_set[7] = USG_PEND_SET;
    hs_set[8] = MEM_PEND_SET;
    hs_clr[7] = HND_ENTER[2];
    hs_clr[8] = HND_ENTER[0];
  end

  genvar gi;
  generate
    for (gi = 0; gi < fsh_pkg::N_HANDLERS; gi++) begin : g_hs
      // direct software write of pending and active state
      fsh_flag u_flag (
        .clk(CLK),
        .resetn(RESETN), // see RULE13
        .hw_set(hs_set[gi]),
        .hw_clr(hs_clr[gi]),
        .sw_wr(wr_hs), // see RULE1 see RULE2
        .sw_val(WDATA[slot_bit(gi)]),
        .q(hs_q[gi])
      );
      assign hs_word[slot_bit(gi)] = hs_q[gi]; // see RULE3 see RULE4
    end
  endgenerate

  // fill the unused handler register bits with zero
  generate
    for (gi = 0; gi < 32; gi++) begin : g_hs_pad
      if (fsh_pkg::HS_MASK[gi] == 1'b0) begin : g_z
        assign hs_word[gi] = 1'b0;
      end
    end
  endgenerate

  fsh_cfsr_byte u_mm (
    .clk(CLK),
    .resetn(RESETN),
    .ev_iacc(FLT_IACC), // see RULE7 see RULE8
    .ev_dacc(FLT_DACC), // see RULE9
    .ev_addr(FLT_ADDR),
    .ev_unstk(FLT_UNSTK), // see RULE10
    .ev_stk(FLT_STK), // see RULE11
    .w1c(wr_cf),
    .w1c_data(WDATA[7:0]),
    .status(mm_status),
    .fault_addr(fault_addr)
  );

  // usage detail bits: set wins over a write-one clear
  always_comb begin
    ud_next = ud_reg;
    if (wr_cf) begin
      ud_next = ud_reg & ~WDATA[fsh_pkg::CF_DIVZERO:fsh_pkg::CF_MISALIGNED_ACCESS_FLAG];
    end
    if (FLT_MISALIGNED_ACCESS_FLAG) begin
      ud_next[0] = 1'b1;
    end
    if (FLT_DIVZERO) begin
      ud_next[1] = 1'b1;
    end
  end

  always_comb begin
    cf_word = 32'h00000000; // see RULE12
    cf_word[7:0] = mm_status;
    cf_word[fsh_pkg::CF_MISALIGNED_ACCESS_FLAG] = ud_reg[0];
    cf_word[fsh_pkg::CF_DIVZERO] = ud_reg[1];
  end

  // unmapped reads return zero; the port never waits
  always_comb begin
    rdata_next = 32'h00000000; // see RULE14
    if (RD) begin
      if (hit(ADDR, fsh_pkg::OFF_HANDLER)) begin
        rdata_next = hs_word;
      end else if (hit(ADDR, fsh_pkg::OFF_CFSR)) begin
        rdata_next = cf_word;
      end else if (hit(ADDR, fsh_pkg::OFF_FAULT_ADDR)) begin
        rdata_next = fault_addr;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ud_reg <= fsh_pkg::CF_RESET[25:24]; // see RULE12 see RULE13
      rdata_reg <= 32'h00000000;
    end else begin
      ud_reg <= ud_next;
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA = rdata_reg;
  assign HND_STATE = hs_q;

  property p_iacc_sets;
    @(posedge CLK) disable iff (!RESETN)
      FLT_IACC |=> mm_status[fsh_pkg::CF_IACC];
  endproperty
  a_iacc_sets: assert property (p_iacc_sets) // see RULE7
    else $error("instruction violation flag not set");

  property p_iacc_no_addr;
    @(posedge CLK) disable iff (!RESETN)
      (FLT_IACC && !FLT_DACC) |=> $stable(fault_addr);
  endproperty
  a_iacc_no_addr: assert property (p_iacc_no_addr) // see RULE8
    else $error("fault address changed on instruction violation");

  property p_dacc_addr;
    @(posedge CLK) disable iff (!RESETN)
      FLT_DACC |=> (fault_addr == $past(FLT_ADDR)) && mm_status[1];
  endproperty
  a_dacc_addr: assert property (p_dacc_addr) // see RULE9
    else $error("data violation address not captured");

  property p_unstk;
    @(posedge CLK) disable iff (!RESETN)
      (FLT_UNSTK && !FLT_DACC) |=> mm_status[3] && $stable(fault_addr);
  endproperty
  a_unstk: assert property (p_unstk) // see RULE10
    else $error("unstacking fault not recorded correctly");

  property p_stk;
    @(posedge CLK) disable iff (!RESETN)
      (FLT_STK && !FLT_DACC) |=> mm_status[4] && $stable(fault_addr);
  endproperty
  a_stk: assert property (p_stk) // see RULE11
    else $error("stacking fault not recorded correctly");

  property p_pend_write;
    @(posedge CLK) disable iff (!RESETN)
      (wr_hs && !MEM_PEND_SET && !HND_ENTER[0])
        |=> hs_q[8] == $past(WDATA[fsh_pkg::HS_MEM_PEND]);
  endproperty
  a_pend_write: assert property (p_pend_write) // see RULE1
    else $error("pending flag ignored software write");

  property p_tick_write;
    @(posedge CLK) disable iff (!RESETN)
      (wr_hs && !HND_ENTER[6] && !HND_RETURN[6])
        |=> hs_q[6] == $past(WDATA[fsh_pkg::HS_TICK_ACT]);
  endproperty
  a_tick_write: assert property (p_tick_write) // see RULE2
    else $error("active flag ignored software write");

  property p_active_track;
    @(posedge CLK) disable iff (!RESETN)
      (HND_ENTER[3] ##1 (!WR && !HND_RETURN[3]))
        |-> hs_word[fsh_pkg::HS_SVC_ACT];
  endproperty
  a_active_track: assert property (p_active_track) // see RULE3
    else $error("supervisor call active not shown");

  property p_fault_act;
    @(posedge CLK) disable iff (!RESETN)
      (HND_RETURN[1] && !HND_ENTER[1] && !wr_hs) |=> !hs_q[1];
  endproperty
  a_fault_act: assert property (p_fault_act) // see RULE4
    else $error("bus fault active not cleared on return");

  property p_reset_zero;
    @(posedge CLK) !RESETN |=> (cf_word == 32'h00000000) && (hs_q == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) // see RULE12 see RULE13
    else $error("state not cleared by core reset");

  property p_read_one;
    @(posedge CLK) disable iff (!RESETN)
      !RD |=> RDATA == 32'h00000000;
  endproperty
  a_read_one: assert property (p_read_one) // see RULE14
    else $error("read data outside read cycle");

  property p_usg_pend_write;
    @(posedge CLK) disable iff (!RESETN)
      (wr_hs && !USG_PEND_SET && !HND_ENTER[2])
        |=> hs_q[7] == $past(WDATA[fsh_pkg::HS_USG_PEND]);
  endproperty
  a_usg_pend_write: assert property (p_usg_pend_write) // see RULE1
    else $error("usage pending flag ignored software write");

  property p_pend_set;
    @(posedge CLK) disable iff (!RESETN)
      MEM_PEND_SET |=> hs_q[8];
  endproperty
  a_pend_set: assert property (p_pend_set) // see RULE1
    else $error("pending flag not set by core");

  // entering the handler consumes its pending state
  property p_pend_taken;
    @(posedge CLK) disable iff (!RESETN)
      (HND_ENTER[0] && !MEM_PEND_SET) |=> !hs_q[8] && hs_q[0];
  endproperty
  a_pend_taken: assert property (p_pend_taken) // see RULE1
    else $error("pending flag kept after handler entry");

  property p_psv_return;
    @(posedge CLK) disable iff (!RESETN)
      (HND_RETURN[5] && !HND_ENTER[5] && !wr_hs)
        |=> !hs_word[fsh_pkg::HS_PSV_ACT];
  endproperty
  a_psv_return: assert property (p_psv_return) // see RULE3
    else $error("pendable service active not cleared on return");

  property p_divzero;
    @(posedge CLK) disable iff (!RESETN)
      FLT_DIVZERO |=> cf_word[fsh_pkg::CF_DIVZERO];
  endproperty
  a_divzero: assert property (p_divzero) // see RULE12
    else $error("divide by zero flag not set");

  property p_misaligned_access_flag;
    @(posedge CLK) disable iff (!RESETN)
      FLT_MISALIGNED_ACCESS_FLAG |=> cf_word[fsh_pkg::CF_MISALIGNED_ACCESS_FLAG];
  endproperty
  a_misaligned_access_flag: assert property (p_misaligned_access_flag) // see RULE12
    else $error("misaligned access flag not set");

  property p_read_status;
    @(posedge CLK) disable iff (!RESETN)
      (RD && hit(ADDR, fsh_pkg::OFF_CFSR)) |=> RDATA == $past(cf_word);
  endproperty
  a_read_status: assert property (p_read_status) // see RULE12
    else $error("fault status read data wrong");
endmodule : fsh_top
`default_nettype wire

// ### sim/fsh_core_model.sv
// fsh_core_model: stands in for the core's exception entry and return
// logic, driving one-cycle event pulses into the block.
// assumes one caller thread; events change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module fsh_core_model (
  input wire logic clk,
  output logic [8:0] hnd_enter,
  output logic [8:0] hnd_return,
  output logic mem_pend_set,
  output logic usg_pend_set,
  output logic flt_iacc,
  output logic flt_dacc,
  output logic [31:0] flt_addr,
  output logic flt_unstk,
  output logic flt_stk,
  output logic flt_misaligned_access_flag,
  output logic flt_divzero
);
  initial begin
    {hnd_enter, hnd_return} = '0;
    {mem_pend_set, usg_pend_set, flt_iacc, flt_dacc} = '0;
    {flt_unstk, flt_stk, flt_misaligned_access_flag, flt_divzero} = '0;
    flt_addr = '0;
  end

  // ev: [8:0] enter, [17:9] return, 18 mem pend, 19 usage pend,
  // 20 iacc, 21 dacc, 22 unstk, 23 stk, 24 misaligned_access_flag, 25 divzero
  task automatic fire(input logic [25:0] ev, input logic [31:0] addr);
    @(posedge clk);
    {flt_divzero, flt_misaligned_access_flag, flt_stk, flt_unstk, flt_dacc, flt_iacc,
     usg_pend_set, mem_pend_set, hnd_return, hnd_enter} <= ev;
    flt_addr <= addr;
    @(posedge clk);
    {flt_divzero, flt_misaligned_access_flag, flt_stk, flt_unstk, flt_dacc, flt_iacc,
     usg_pend_set, mem_pend_set, hnd_return, hnd_enter} <= '0;
    // address is only meaningful in the event cycle; never leave it stale
    flt_addr <= ~addr;
    #1;
  endtask : fire
endmodule : fsh_core_model
`default_nettype wire

// ### sim/fault_status_handler_state_tb.sv
// fault_status_handler_state_tb: register-port and event tests.
// assumes fsh_top and fsh_core_model; no checker file is bound.
`timescale 1ns/1ps
`default_nettype none
module fault_status_handler_state_tb;
  logic CLK;
  logic RESETN;
  logic [7:0] ADDR;
  logic [31:0] WDATA;
  logic [31:0] RDATA;
  logic WR;
  logic RD;
  logic [8:0] HND_ENTER;
  logic [8:0] HND_RETURN;
  logic [8:0] HND_STATE;
  logic MEM_PEND_SET, USG_PEND_SET, FLT_IACC, FLT_DACC;
  logic FLT_UNSTK, FLT_STK, FLT_MISALIGNED_ACCESS_FLAG, FLT_DIVZERO;
  logic [31:0] FLT_ADDR;
  logic [31:0] saved;
  int bad_count = 0;
  int tests_run = 0;
  int unsigned act_bit [7] = '{fsh_pkg::HS_MEM_ACT, fsh_pkg::HS_BUS_ACT,
    fsh_pkg::HS_USG_ACT, fsh_pkg::HS_SVC_ACT, fsh_pkg::HS_MON_ACT,
    fsh_pkg::HS_PSV_ACT, fsh_pkg::HS_TICK_ACT};

  fsh_core_model i_core (.clk(CLK), .hnd_enter(HND_ENTER),
    .hnd_return(HND_RETURN), .mem_pend_set(MEM_PEND_SET),
    .usg_pend_set(USG_PEND_SET), .flt_iacc(FLT_IACC), .flt_dacc(FLT_DACC),
    .flt_addr(FLT_ADDR), .flt_unstk(FLT_UNSTK), .flt_stk(FLT_STK),
    .flt_misaligned_access_flag(FLT_MISALIGNED_ACCESS_FLAG), .flt_divzero(FLT_DIVZERO));

  fsh_top i_dut (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .HND_ENTER(HND_ENTER),
    .HND_RETURN(HND_RETURN), .MEM_PEND_SET(MEM_PEND_SET),
    .USG_PEND_SET(USG_PEND_SET), .FLT_IACC(FLT_IACC), .FLT_DACC(FLT_DACC),
    .FLT_ADDR(FLT_ADDR), .FLT_UNSTK(FLT_UNSTK), .FLT_STK(FLT_STK),
    .FLT_MISALIGNED_ACCESS_FLAG(FLT_MISALIGNED_ACCESS_FLAG), .FLT_DIVZERO(FLT_DIVZERO),
    .HND_STATE(HND_STATE));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic summarize;
    $display("checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask : reg_rd

  task automatic expect_rd(input string name, input logic [7:0] a,
                           input logic [31:0] exp);
    logic [31:0] d;
    reg_rd(a, d);
    check(name, d, exp);
  endtask : expect_rd

  initial begin
    repeat (3000) @(posedge CLK);
    bad_count++;
    $display("Error watchdog expected end of tests seen timeout");
    summarize();
  end

  initial begin
    RESETN = 1'b0;
    {WR, RD, ADDR, WDATA} = '0;
    repeat (20) @(posedge CLK);
    RESETN <= 1'b1;
    expect_rd("handler reset", fsh_pkg::OFF_HANDLER, 32'h0);
    expect_rd("status reset", fsh_pkg::OFF_CFSR, 32'h0);
    expect_rd("address reset", fsh_pkg::OFF_FAULT_ADDR, 32'h0);
    @(posedge CLK);
    #1 check("rdata idle", RDATA, 32'h0);
    for (int i = 0; i < 7; i++) begin
      i_core.fire(26'(1) << i, 32'h0);
      check("state enter", 32'(HND_STATE), 32'(1) << i);
      expect_rd("active", 8'h00, 32'(1) << act_bit[i]);
      i_core.fire(26'(1) << (i + 9), 32'h0);
      check("state return", 32'(HND_STATE), 32'h0);
    end
    i_core.fire(26'h00C0000, 32'h0);
    expect_rd("pending set", 8'h00, 32'h00003000);
    i_core.fire(26'h0000001, 32'h0);
    check("pending taken", 32'(HND_STATE), 32'h00000081);
    reg_wr(fsh_pkg::OFF_HANDLER, 32'h0);
    expect_rd("pending clear", 8'h00, 32'h0);
    reg_wr(fsh_pkg::OFF_HANDLER, 32'h00001000);
    reg_rd(fsh_pkg::OFF_HANDLER, saved);
    check("pending write", saved, 32'h00001000);
    reg_wr(fsh_pkg::OFF_HANDLER, saved | 32'h00000800);
    expect_rd("modify one bit", 8'h00, 32'h00001800);
    check("tick state", 32'(HND_STATE[6]), 32'h1);
    reg_wr(fsh_pkg::OFF_HANDLER, saved);
    expect_rd("restored", 8'h00, 32'h00001000);
    reg_wr(fsh_pkg::OFF_HANDLER, 32'hFFFFFFFF);
    expect_rd("all flags", 8'h00, fsh_pkg::HS_MASK);
    check("all state", 32'(HND_STATE), 32'h000001FF);
    i_core.fire(26'(1) << 20, 32'hA5A50000);
    expect_rd("iacc", 8'h04, 32'h00000001);
    expect_rd("iacc address", 8'h08, 32'h0);
    i_core.fire(26'(1) << 21, 32'h20000010);
    expect_rd("dacc", 8'h04, 32'h00000083);
    expect_rd("dacc address", 8'h08, 32'h20000010);
    i_core.fire(26'(1) << 22, 32'h55555555);
    expect_rd("unstk", 8'h04, 32'h0000008B);
    expect_rd("unstk address", 8'h08, 32'h20000010);
    i_core.fire(26'(1) << 23, 32'h66666666);
    expect_rd("stk", 8'h04, 32'h0000009B);
    expect_rd("stk address", 8'h08, 32'h20000010);
    i_core.fire(26'h3000000, 32'h0);
    expect_rd("div and misaligned_access_flag", 8'h04, fsh_pkg::CF_MASK);
    reg_wr(fsh_pkg::OFF_CFSR, 32'h01000001);
    expect_rd("clear by one", 8'h04, 32'h0200009A);
    reg_wr(8'h0C, 32'hFFFFFFFF);
    expect_rd("unmapped", 8'h0C, 32'h0);
    expect_rd("unmapped write", 8'h04, 32'h0200009A);
    @(posedge CLK);
    RESETN <= 1'b0;
    @(posedge CLK);
    RESETN <= 1'b1;
    #1 check("state warm reset", 32'(HND_STATE), 32'h0);
    expect_rd("handler warm", 8'h00, 32'h0);
    expect_rd("status warm", 8'h04, 32'h0);
    expect_rd("address warm", 8'h08, 32'h0);
    summarize();
  end
endmodule : fault_status_handler_state_tb
`default_nettype wire
